// ===== rtl/dsgsr_masked_reg.sv
`default_nettype none
module dsgsr_masked_reg
  import dsgsr_pkg::*;
#(
  parameter logic [11:0] OFFSET = 12'h000,
  parameter logic [31:0] WMASK = 32'hffff_ffff
) (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, low
  input wire logic [31:0] capMask, // extra write mask
  dsgsr_reg_if.slave bus, // register access
  output logic [31:0] value // stored value
);
  wire selected = (bus.addr == OFFSET);
  wire [31:0] laneMask = {{8{bus.sel[3]}}, {8{bus.sel[2]}}, {8{bus.sel[1]}}, {8{bus.sel[0]}}};
  wire [31:0] wMask = WMASK & capMask & laneMask;
  wire [31:0] next_value = (value & ~wMask) | (bus.wrData & wMask);
  assign bus.hit = selected;
  assign bus.rdData = selected ? value : RESET_ZERO;
  // reserved bits never store, so they read zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      value <= RESET_ZERO;
    end else if (bus.wrEn && selected) begin
      value <= next_value;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dsgsr_pkg.sv
`default_nettype none
package dsgsr_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_SOFT_RESET_0 = 12'h040;
  localparam logic [11:0] OFF_DEEP_GATE_2 = 12'h128;
  localparam logic [11:0] OFF_RUN_GATE_2 = 12'h108;
  localparam logic [11:0] OFF_SLEEP_GATE_2 = 12'h118;
  localparam logic [11:0] OFF_RUN_CLOCK_CONFIG = 12'h060;
  localparam logic [11:0] OFF_POWER_MODE = 12'h200;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h204;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h208;
  localparam logic [11:0] OFF_FAULT_ADDR = 12'h20c;
  // writable bits: usb 16, micro-dma 13, ports h..a 7..0
  localparam logic [31:0] GATE_WMASK = 32'h0001_20ff;
  // can 24, converter 16, hibernation 6, watchdog 3
  localparam logic [31:0] SRST_WMASK = 32'h0101_0048;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam int AUTO_GATING_BIT = 27;
  localparam logic [31:0] RCC_WMASK = 32'h0800_0000;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_MODE_BIT = 1;
  localparam int IRQ_BITS = 2;
  localparam int GATE_UNITS = 10;
  // unit index order: ports a..h, then micro-dma, then usb
  localparam int PORT_UNITS = 8;
  localparam int DMA_UNIT = 8;
  localparam int DMA_GATE_POS = 13;
  localparam int USB_GATE_POS = 16;
  // held reset control positions in the soft reset word
  localparam int CAN_RESET_POS = 24;
  localparam int CONV_RESET_POS = 16;
  localparam int HIB_RESET_POS = 6;
  localparam int WDOG_RESET_POS = 3;
  typedef enum logic [1:0] {
    DSGSR_RUN = 2'h0,
    DSGSR_SLEEP = 2'h1,
    DSGSR_DEEP = 2'h2
  } dsgsr_mode_type;
  typedef enum logic [2:0] {
    DSGSR_IDLE = 3'h1,
    DSGSR_ACK = 3'h2,
    DSGSR_ERR = 3'h4
  } dsgsr_bus_state_type;
  // unit index to gate bit position
  function automatic int gate_bit_pos(input int unit);
    if (unit < PORT_UNITS) begin
      gate_bit_pos = unit;
    end else if (unit == DMA_UNIT) begin
      gate_bit_pos = DMA_GATE_POS;
    end else begin
      gate_bit_pos = USB_GATE_POS;
    end
  endfunction
endpackage
`default_nettype wire

// ===== rtl/dsgsr_reg_if.sv
`default_nettype none
interface dsgsr_reg_if;
  logic wrEn;
  logic [11:0] addr;
  logic [31:0] wrData;
  logic [3:0] sel;
  logic [31:0] rdData;
  logic hit;
  modport master (output wrEn, addr, wrData, sel, input rdData, hit);
  modport slave (input wrEn, addr, wrData, sel, output rdData, hit);
endinterface
`default_nettype wire

// ===== rtl/dsgsr_top.sv
// Function
// - gate bit one clocks unit, zero stops
// - access to gated unit gives a fault pulse on unitFault
// - deep-sleep gating register resets to zero
// - run, sleep, deep-sleep registers apply per mode only with auto gating
// - sleep registers used only with auto gating
// - bit 16 usb, bit 13 micro-dma
// - bits 7..0 gate ports h..a
// - reserved bits read zero, stay unchanged
// - reset writes masked by capability bits
// - bit 24 can, bit 16 converter
// - bit 6 hibernation, bit 3 watchdog
// - soft reset register resets to zero
`default_nettype none
module dsgsr_top
  import dsgsr_pkg::*;
(
  input wire logic clk, // 40 MHz system clock
  input wire logic nrst, // sync reset, low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [11:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // normal completion
  output logic wb_err_o, // bus fault
  input wire logic [31:0] capability_word_1, // unit capability bits
  input wire logic [GATE_UNITS-1:0] unitAccess, // access aimed at unit
  output logic [GATE_UNITS-1:0] unitFault, // fault pulse per unit
  output logic [GATE_UNITS-1:0] unitClockEn, // clock enable per unit
  output logic canUnitReset, // can held in reset
  output logic converterReset, // converter held in reset
  output logic hibernationReset, // hibernation held in reset
  output logic watchdogReset, // watchdog held in reset
  output logic irq // level interrupt
);
  // ==================================================
  // register bank
  dsgsr_reg_if srstIf();
  dsgsr_reg_if deepIf();
  dsgsr_reg_if runIf();
  dsgsr_reg_if sleepIf();
  dsgsr_reg_if rccIf();
  logic [31:0] peripheral_soft_reset_0;
  logic [31:0] deep_sleep_clock_gate_2;
  logic [31:0] run_clock_gate_2;
  logic [31:0] sleep_clock_gate_2;
  logic [31:0] run_clock_config;
  logic [1:0] powerMode;
  logic [IRQ_BITS-1:0] irqStatus;
  logic [IRQ_BITS-1:0] irqMask;
  logic [31:0] faultUnits;
  dsgsr_bus_state_type busState;
  wire reqValid = wb_cyc_i && wb_stb_i && (busState == DSGSR_IDLE);
  wire wrStrobe = reqValid && wb_we_i;
  wire [31:0] allOnes = 32'hffff_ffff;
  assign srstIf.wrEn = wrStrobe;
  assign srstIf.addr = wb_adr_i;
  assign srstIf.wrData = wb_dat_i;
  assign srstIf.sel = wb_sel_i;
  assign deepIf.wrEn = wrStrobe;
  assign deepIf.addr = wb_adr_i;
  assign deepIf.wrData = wb_dat_i;
  assign deepIf.sel = wb_sel_i;
  assign runIf.wrEn = wrStrobe;
  assign runIf.addr = wb_adr_i;
  assign runIf.wrData = wb_dat_i;
  assign runIf.sel = wb_sel_i;
  assign sleepIf.wrEn = wrStrobe;
  assign sleepIf.addr = wb_adr_i;
  assign sleepIf.wrData = wb_dat_i;
  assign sleepIf.sel = wb_sel_i;
  assign rccIf.wrEn = wrStrobe;
  assign rccIf.addr = wb_adr_i;
  assign rccIf.wrData = wb_dat_i;
  assign rccIf.sel = wb_sel_i;

  // capability word masks writes to the reset controls
  dsgsr_masked_reg #(.OFFSET(OFF_SOFT_RESET_0), .WMASK(SRST_WMASK)) srstReg (
    .clk(clk), .nrst(nrst), .capMask(capability_word_1),
    .bus(srstIf), .value(peripheral_soft_reset_0)
  );
  dsgsr_masked_reg #(.OFFSET(OFF_DEEP_GATE_2), .WMASK(GATE_WMASK)) deepReg (
    .clk(clk), .nrst(nrst), .capMask(allOnes),
    .bus(deepIf), .value(deep_sleep_clock_gate_2)
  );
  dsgsr_masked_reg #(.OFFSET(OFF_RUN_GATE_2), .WMASK(GATE_WMASK)) runReg (
    .clk(clk), .nrst(nrst), .capMask(allOnes),
    .bus(runIf), .value(run_clock_gate_2)
  );
  dsgsr_masked_reg #(.OFFSET(OFF_SLEEP_GATE_2), .WMASK(GATE_WMASK)) sleepReg (
    .clk(clk), .nrst(nrst), .capMask(allOnes),
    .bus(sleepIf), .value(sleep_clock_gate_2)
  );
  dsgsr_masked_reg #(.OFFSET(OFF_RUN_CLOCK_CONFIG), .WMASK(RCC_WMASK)) rccReg (
    .clk(clk), .nrst(nrst), .capMask(allOnes),
    .bus(rccIf), .value(run_clock_config)
  );

  // ==================================================
  // mode selection of the active gating word
  wire autoGating = run_clock_config[AUTO_GATING_BIT];
  wire [31:0] activeGate =
    !autoGating ? run_clock_gate_2 :
    (powerMode == DSGSR_DEEP) ? deep_sleep_clock_gate_2 :
    (powerMode == DSGSR_SLEEP) ? sleep_clock_gate_2 :
    run_clock_gate_2;

  // ==================================================
  // per-unit enables and faults
  logic [GATE_UNITS-1:0] faultNow;
  genvar u;
  generate
    for (u = 0; u < GATE_UNITS; u++) begin : gUnit
      always_ff @(posedge clk) begin
        if (!nrst) begin
          unitClockEn[u] <= 1'b0;
          unitFault[u] <= 1'b0;
        end else begin
          unitClockEn[u] <= activeGate[gate_bit_pos(u)];
          unitFault[u] <= faultNow[u];
        end
      end
      // judged against the enable the unit sees now, not the one coming next
      assign faultNow[u] = unitAccess[u] && !unitClockEn[u];
    end
  endgenerate
  wire anyFault = |faultNow;
  wire [31:0] faultWord = {{(32-GATE_UNITS){1'b0}}, faultNow};

  // held resets follow the register level
  always_ff @(posedge clk) begin
    if (!nrst) begin
      canUnitReset <= 1'b0;
      converterReset <= 1'b0;
      hibernationReset <= 1'b0;
      watchdogReset <= 1'b0;
    end else begin
      canUnitReset <= peripheral_soft_reset_0[CAN_RESET_POS];
      converterReset <= peripheral_soft_reset_0[CONV_RESET_POS];
      hibernationReset <= peripheral_soft_reset_0[HIB_RESET_POS];
      watchdogReset <= peripheral_soft_reset_0[WDOG_RESET_POS];
    end
  end

  // ==================================================
  // local control, status and interrupt registers
  wire selMode = (wb_adr_i == OFF_POWER_MODE);
  wire selStat = (wb_adr_i == OFF_IRQ_STATUS);
  wire selMask = (wb_adr_i == OFF_IRQ_MASK);
  wire selFault = (wb_adr_i == OFF_FAULT_ADDR);
  wire localHit = selMode || selStat || selMask || selFault;
  wire modeWrite = wrStrobe && selMode && wb_sel_i[0];
  wire [1:0] next_powerMode = (wb_dat_i[1:0] == 2'h3) ? powerMode : wb_dat_i[1:0];
  wire modeChange = modeWrite && (next_powerMode != powerMode);
  wire [IRQ_BITS-1:0] irqEvent = {modeChange, anyFault};
  wire [IRQ_BITS-1:0] irqClear = (wrStrobe && selStat && wb_sel_i[0]) ?
    wb_dat_i[IRQ_BITS-1:0] : {IRQ_BITS{1'b0}};
  // set wins over a clear in the same cycle
  wire [IRQ_BITS-1:0] next_irqStatus = (irqStatus & ~irqClear) | irqEvent;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      powerMode <= DSGSR_RUN;
      irqStatus <= '0;
      irqMask <= '0;
      faultUnits <= RESET_ZERO;
    end else begin
      if (modeWrite) powerMode <= next_powerMode;
      irqStatus <= next_irqStatus;
      if (wrStrobe && selMask && wb_sel_i[0]) irqMask <= wb_dat_i[IRQ_BITS-1:0];
      if (anyFault) faultUnits <= faultWord;
    end
  end
  assign irq = |(irqStatus & irqMask);

  // ==================================================
  // wishbone answer: ack for mapped, err for unmapped
  wire regHit = srstIf.hit || deepIf.hit || runIf.hit || sleepIf.hit || rccIf.hit;
  wire [31:0] localData =
    selMode ? {30'h0, powerMode} :
    selStat ? {{(32-IRQ_BITS){1'b0}}, irqStatus} :
    selMask ? {{(32-IRQ_BITS){1'b0}}, irqMask} :
    selFault ? faultUnits : RESET_ZERO;
  wire [31:0] readMux = srstIf.rdData | deepIf.rdData | runIf.rdData |
    sleepIf.rdData | rccIf.rdData | localData;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busState <= DSGSR_IDLE;
      wb_dat_o <= RESET_ZERO;
    end else begin
      case (busState)
        DSGSR_IDLE: begin
          if (reqValid) begin
            busState <= (regHit || localHit) ? DSGSR_ACK : DSGSR_ERR;
            wb_dat_o <= wb_we_i ? RESET_ZERO : readMux;
          end
        end
        DSGSR_ACK: busState <= DSGSR_IDLE;
        DSGSR_ERR: busState <= DSGSR_IDLE;
        default: busState <= DSGSR_IDLE;
      endcase
    end
  end
  assign wb_ack_o = (busState == DSGSR_ACK);
  assign wb_err_o = (busState == DSGSR_ERR);
endmodule
`default_nettype wire

// ===== tb/dsgsr_bench.sv
`default_nettype none
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin numErrors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
// ==========
// register bus driver and scenarios
module dsgsr_bench import dsgsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, e;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, cap = 32'h0, rdat, rd;
  logic [GATE_UNITS-1:0] acc = '0, fault, clkEn;
  logic ack, err, canRst, convRst, hibRst, wdRst, irq;
  int numErrors = 0, samplesChecked = 0;
  always #12.5 clk = ~clk;
  dsgsr_top dsgsr_top_inst (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .capability_word_1(cap), .unitAccess(acc),
    .unitFault(fault), .unitClockEn(clkEn), .canUnitReset(canRst),
    .converterReset(convRst), .hibernationReset(hibRst), .watchdogReset(wdRst), .irq(irq));
  // request stands until ack or err is seen at a rising edge; the watchdog ends a hang
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] ex, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_gate;
    rdchk(OFF_DEEP_GATE_2, 32'h0, "gate reset");
    rdchk(OFF_SOFT_RESET_0, 32'h0, "srst reset");
    bus(1'b1, OFF_RUN_CLOCK_CONFIG, 32'h0800_0000);
    bus(1'b1, OFF_POWER_MODE, 32'h2);
    bus(1'b1, OFF_DEEP_GATE_2, 32'hffff_ffff);
    rdchk(OFF_DEEP_GATE_2, 32'h0001_20ff, "gate bits");
    settle;
    `CHK("clkEn all", 10'h3ff, clkEn)
    bus(1'b1, OFF_DEEP_GATE_2, 32'h0000_2005);
    settle;
    `CHK("clkEn some", 10'h105, clkEn)
    @(posedge clk);
    acc <= '1;
    @(posedge clk);
    acc <= '0;
    @(negedge clk);
    `CHK("fault", 10'h2fa, fault)
    bus(1'b1, OFF_IRQ_MASK, 32'h1);
    settle;
    `CHK("irq set", 1'b1, irq)
    bus(1'b1, OFF_IRQ_STATUS, 32'h3);
    settle;
    `CHK("irq clear", 1'b0, irq)
    bus(1'b1, OFF_RUN_GATE_2, 32'h0001_0001);
    bus(1'b1, OFF_SLEEP_GATE_2, 32'h0000_2080);
    bus(1'b1, OFF_POWER_MODE, 32'h1);
    settle;
    `CHK("sleep mode", 10'h180, clkEn)
    bus(1'b1, OFF_POWER_MODE, 32'h3);
    rdchk(OFF_POWER_MODE, 32'h1, "mode code 3 ignored");
    bus(1'b1, OFF_RUN_CLOCK_CONFIG, 32'h0);
    settle;
    `CHK("no auto gating", 10'h201, clkEn)
    bus(1'b1, OFF_RUN_CLOCK_CONFIG, 32'h0800_0000);
    bus(1'b1, OFF_POWER_MODE, 32'h0);
    settle;
    `CHK("run mode", 10'h201, clkEn)
  endtask
  task automatic t_srst;
    @(posedge clk);
    cap <= 32'h0000_0048;
    bus(1'b1, OFF_SOFT_RESET_0, 32'hffff_ffff);
    rdchk(OFF_SOFT_RESET_0, 32'h0000_0048, "srst masked");
    settle;
    `CHK("resets hib wdt", 4'h3, {canRst, convRst, hibRst, wdRst})
    @(posedge clk);
    cap <= 32'hffff_ffff;
    bus(1'b1, OFF_SOFT_RESET_0, 32'h0101_0000);
    rdchk(OFF_SOFT_RESET_0, 32'h0101_0000, "srst can adc");
    settle;
    `CHK("resets can adc", 4'hc, {canRst, convRst, hibRst, wdRst})
    bus(1'b1, OFF_SOFT_RESET_0, 32'h0);
    settle;
    `CHK("resets off", 4'h0, {canRst, convRst, hibRst, wdRst})
    bus(1'b0, 12'h300, 32'h0);
    `CHK("unmapped err", 1'b1, e)
  endtask
  // reset in mid-run, then a single-lane write
  task automatic t_reset;
    bus(1'b1, OFF_SOFT_RESET_0, 32'h0101_0048);
    bus(1'b1, OFF_POWER_MODE, 32'h2);
    bus(1'b1, OFF_DEEP_GATE_2, 32'h0000_00ff);
    settle;
    `CHK("before reset", 10'h0ff, clkEn)
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdchk(OFF_DEEP_GATE_2, 32'h0, "gate after reset");
    rdchk(OFF_SOFT_RESET_0, 32'h0, "srst after reset");
    `CHK("outputs after reset", 14'h0, {clkEn, canRst, convRst, hibRst, wdRst})
    @(posedge clk);
    sel <= 4'h4;
    bus(1'b1, OFF_DEEP_GATE_2, 32'hffff_ffff);
    @(posedge clk);
    sel <= 4'hf;
    rdchk(OFF_DEEP_GATE_2, 32'h0001_0000, "lane write");
  endtask
  initial begin
    #(4000 * 25);
    numErrors++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_gate();
    t_srst();
    t_reset();
    conclude();
  end
endmodule
bind dsgsr_top dsgsr_top_monitor dsgsr_top_monitor_inst (.clk(clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .capability_word_1(capability_word_1), .unitAccess(unitAccess), .unitFault(unitFault),
  .unitClockEn(unitClockEn), .canUnitReset(canUnitReset), .watchdogReset(watchdogReset));
`default_nettype wire

// ===== tb/dsgsr_top_monitor.sv
`default_nettype none
// ==========
// port-level checks
module dsgsr_top_monitor
  import dsgsr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, low
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [11:0] wb_adr_i, // address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic wb_ack_o, // ack
  input wire logic wb_err_o, // error
  input wire logic [31:0] capability_word_1, // capability
  input wire logic [GATE_UNITS-1:0] unitAccess, // unit access
  input wire logic [GATE_UNITS-1:0] unitFault, // unit fault
  input wire logic [GATE_UNITS-1:0] unitClockEn, // clock enables
  input wire logic canUnitReset, // can reset
  input wire logic watchdogReset // watchdog reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic srWr;
  logic anyWr;
  assign srWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == OFF_SOFT_RESET_0;
  assign anyWr = wb_cyc_i && wb_stb_i && wb_we_i;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_ANSWER_CAUSE: assert property ((wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_ERR: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  AST_OUT_RESET: assert property (
    $rose(nrst) |-> unitClockEn == '0 && !canUnitReset && !watchdogReset)
    else $error("outputs not cleared by reset");
  AST_FAULT_GATED: assert property (unitFault == $past(unitAccess & ~unitClockEn))
    else $error("fault does not follow gated access");
  AST_GATE_CAUSE: assert property (
    $changed(unitClockEn) |-> $past(anyWr) || $past(anyWr, 2))
    else $error("clock enable changed without write");
  AST_CAN_MASK: assert property (
    $changed(canUnitReset) |-> $past(srWr && capability_word_1[24]) ||
      $past(srWr && capability_word_1[24], 2))
    else $error("can reset changed without permitted write");
  AST_WDOG_SET: assert property (
    $rose(watchdogReset) |-> $past(srWr && wb_dat_i[3] && capability_word_1[3]) ||
      $past(srWr && wb_dat_i[3] && capability_word_1[3], 2))
    else $error("watchdog reset set without permitted write");
endmodule
`default_nettype wire
